// *** rtl/csc_pkg.sv ***
/*
 Package for the configuration store command unit: register offsets, field layout,
 reset values, command codes and timing counts.
 Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package csc_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned RESET_DELAY_MS  = 100;
   localparam int unsigned RESET_DELAY_CYC = (CLK_HZ / 1000) * RESET_DELAY_MS;

   // register byte offsets
   localparam logic [7:0] OFS_CMD      = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_PARAM_IX = 8'h08;
   localparam logic [7:0] OFS_PARAM_WD = 8'h0c;
   localparam logic [7:0] OFS_PEND_RD  = 8'h10;
   localparam logic [7:0] OFS_ACT_RD   = 8'h14;
   localparam logic [7:0] OFS_FW_VER   = 8'h18;
   localparam logic [7:0] OFS_HW_VAR   = 8'h1c;
   localparam logic [7:0] OFS_POWER    = 8'h20;
   localparam logic [7:0] OFS_SUPPLY   = 8'h24;
   localparam logic [7:0] OFS_TEMP     = 8'h28;
   localparam logic [7:0] OFS_CRC      = 8'h2c;
   localparam logic [7:0] OFS_FW_COMPAT = 8'h30;
   localparam logic [7:0] OFS_RATE     = 8'h34;

   // command register fields
   localparam int CMD_CODE_LSB   = 0;
   localparam int CMD_CODE_W     = 4;
   localparam int CMD_REMOTE_BIT = 8;
   localparam int CMD_OPT1_BIT   = 9;

   // parameter store shape: three location strings of 16 bytes and one rate word
   localparam int NUM_PARAMS   = 49;
   localparam int PARAM_IX_W   = 6;
   localparam int LOC_LEN      = 16;
   localparam int RATE_IX      = 48;
   localparam logic [7:0] LOC_DEFAULT  = 8'h20;
   localparam logic [7:0] RATE_DEFAULT = 8'h03;
   localparam logic [7:0] FW_VER_MIN_HI = 8'h20;

   // status bits
   localparam int ST_CMD_MODE  = 0;
   localparam int ST_RST_PEND  = 1;
   localparam int ST_NVM_BUSY  = 2;
   localparam int ST_CAPTURE   = 3;
   localparam int ST_BOOT_BAD  = 4;
   localparam int ST_REJECT    = 5;

   typedef enum logic [3:0] {
      CMD_NOP       = 4'h0,
      CMD_APPLY     = 4'h1,
      CMD_LEAVE     = 4'h2,
      CMD_TIMEOUT   = 4'h3,
      CMD_FRAME08   = 4'h4,
      CMD_FRAME17   = 4'h5,
      CMD_WRITE     = 4'h6,
      CMD_SAVED_LD  = 4'h7,
      CMD_CAPTURE   = 4'h8,
      CMD_CLR_DEF   = 4'h9,
      CMD_FACT_LD   = 4'ha,
      CMD_SOFT_RST  = 4'hb,
      CMD_BOOTLDR   = 4'hc,
      CMD_ENTER     = 4'hd,
      CMD_SETPARAM  = 4'he
   } csc_cmd_type;

   typedef enum logic [1:0] {
      NV_IDLE = 2'b00,
      NV_COPY = 2'b01
   } csc_nv_type;
endpackage

// *** rtl/csc_top.sv ***
/*
 Configuration store command unit: pending, active, non-volatile, custom-default
 and factory layers of a small parameter set, driven by commands written over AXI4-Lite.
 Assumes an AXI4-Lite master that keeps to one write and one read at a time, and
 measurement inputs that are quasi-static and pass through a two-stage synchroniser.
*/
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - three location strings hold up to fifteen characters, default one space.
// - firmware version reads a fixed value between 0x2000 and 0x2fff.
// - hardware variant reads a fixed sixteen-bit code set at build.
// - power variant reads zero for high power, one for standard.
// - images below compatibility level are refused; boot blocked until valid reload.
// - supply voltage reads as unsigned sixteen-bit millivolts.
// - temperature reads as sixteen-bit two's complement whole degrees.
// - checksum reads a sixteen-bit CRC over the active configuration.
// - bootloader entry only accepted from the local interface.
// - soft reset acknowledged at once, reset output 100 ms later, leaves command mode.
// - apply copies every pending value into the active configuration.
// - leave, timeout, local 0x08 and remote 0x17 with option bit 1 also apply.
// - serial rate output changes only when pending changes are applied.
// - write command copies active values into the non-volatile copy at once.
// - the rate word persists into the non-volatile copy without a write command.
// - saved-defaults load uses custom defaults where set and stays in command mode.
// - custom default commands from a remote frame are rejected.
// - after capture, the next parameter set also lands in the custom defaults.
// - clear erases every custom default, current settings untouched.
// - factory load ignores custom defaults entirely.
module csc_top
   import csc_pkg::*;
#(
   parameter logic [15:0] FW_VERSION = 16'h2001,    // arbitrary value inside range
   parameter logic [15:0] HW_VARIANT = 16'h0055,    // arbitrary value
   parameter logic        POWER_STD  = 1'b1,
   parameter logic [15:0] HW_COMPAT  = 16'h0001,
   parameter int unsigned RST_CYCLES = RESET_DELAY_CYC
)(
   input  wire logic        SYS_CLK,       // system clock
   input  wire logic        RSTN,          // async reset, active low
   input  wire logic [7:0]  S_AWADDR,      // write address
   input  wire logic        S_AWVALID,     // write address valid
   output logic             S_AWREADY,     // write address ready
   input  wire logic [31:0] S_WDATA,       // write data
   input  wire logic [3:0]  S_WSTRB,       // write strobes
   input  wire logic        S_WVALID,      // write data valid
   output logic             S_WREADY,      // write data ready
   output logic [1:0]       S_BRESP,       // write response
   output logic             S_BVALID,      // write response valid
   input  wire logic        S_BREADY,      // write response ready
   input  wire logic [7:0]  S_ARADDR,      // read address
   input  wire logic        S_ARVALID,     // read address valid
   output logic             S_ARREADY,     // read address ready
   output logic [31:0]      S_RDATA,       // read data
   output logic [1:0]       S_RRESP,       // read response
   output logic             S_RVALID,      // read valid
   input  wire logic        S_RREADY,      // read ready
   input  wire logic [15:0] SUPPLY_MV,     // measured supply, mV
   input  wire logic [15:0] TEMP_C,        // temperature, two's complement
   output logic [7:0]       SERIAL_RATE,   // operating serial rate code
   output logic             SOFT_RESET,    // reset request pulse
   output logic             BOOT_ENTER     // bootloader entry pulse
);
   if (RST_CYCLES < 1) begin : g_bad_delay
      $error("reset delay must be at least one cycle");
   end

   // parameter layers
   logic [7:0] pend_q  [NUM_PARAMS];
   logic [7:0] act_q   [NUM_PARAMS];
   logic [7:0] nv_q    [NUM_PARAMS];
   logic [7:0] cdef_q  [NUM_PARAMS];
   logic       cset_q  [NUM_PARAMS];

   logic                  cmd_mode_q;
   logic                  capture_q;
   logic                  reject_q;
   logic                  boot_bad_q;
   logic [PARAM_IX_W-1:0] pix_q;
   logic [31:0]           rst_cnt_q;
   logic                  rst_pend_q;
   logic [15:0]           crc_q;
   logic [15:0]           fw_compat_q;
   logic [15:0]           sup_s1_q, sup_q, tmp_s1_q, tmp_q;

   function automatic logic [7:0] factory_val(input int i);
      return (i == RATE_IX) ? RATE_DEFAULT : ((i % LOC_LEN) == 0 ? LOC_DEFAULT : 8'h00);
   endfunction

   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int k = 0; k < 8; k++) begin
         r = (r[15] ^ b[7-k]) ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
      end
      return r;
   endfunction

   // bus write channel: accept address and data in either order
   logic        aw_got_q, w_got_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        wr_fire;
   assign wr_fire = aw_got_q && w_got_q && !S_BVALID;

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         S_AWREADY <= 1'b0;
         S_WREADY  <= 1'b0;
         S_BVALID  <= 1'b0;
         S_BRESP   <= 2'b00;
      end else begin
         S_AWREADY <= !aw_got_q && !S_AWREADY && !S_BVALID;
         S_WREADY  <= !w_got_q && !S_WREADY && !S_BVALID;
         if (S_AWVALID && S_AWREADY) begin
            aw_got_q <= 1'b1;
            awaddr_q <= S_AWADDR;
         end
         if (S_WVALID && S_WREADY) begin
            w_got_q <= 1'b1;
            wdata_q <= S_WDATA;
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            S_BVALID <= 1'b1;
            // only writable words answer okay; others slverr
            S_BRESP  <= (awaddr_q == OFS_CMD || awaddr_q == OFS_PARAM_IX ||
                         awaddr_q == OFS_PARAM_WD || awaddr_q == OFS_FW_COMPAT)
                        ? 2'b00 : 2'b10;
         end else if (S_BVALID && S_BREADY) begin
            S_BVALID <= 1'b0;
         end
      end
   end

   // decoded command, valid for one cycle when the command word is written
   logic        cmd_go, remote, opt1, wd_go;
   csc_cmd_type cmd;
   assign cmd_go = wr_fire && awaddr_q == OFS_CMD && wdata_q[31:24] == 8'h00;
   assign wd_go  = wr_fire && awaddr_q == OFS_PARAM_WD;
   assign cmd    = csc_cmd_type'(wdata_q[CMD_CODE_LSB +: CMD_CODE_W]);
   assign remote = wdata_q[CMD_REMOTE_BIT];
   assign opt1   = wdata_q[CMD_OPT1_BIT];

   logic apply_ev, def_cmd;
   // leave, timeout and a local/flagged frame apply; the soft reset exit from command mode does not
   assign apply_ev = cmd_go && (cmd == CMD_APPLY || cmd == CMD_LEAVE ||
                                cmd == CMD_TIMEOUT || cmd == CMD_FRAME08 ||
                                (cmd == CMD_FRAME17 && opt1));
   assign def_cmd  = cmd == CMD_CAPTURE || cmd == CMD_CLR_DEF;

   // pending layer: command-mode writes touch only this copy and, after a capture, the custom defaults
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < NUM_PARAMS; i++) pend_q[i] <= factory_val(i);
      end else if (cmd_go && cmd == CMD_FACT_LD) begin
         for (int i = 0; i < NUM_PARAMS; i++) pend_q[i] <= factory_val(i);
      end else if (cmd_go && cmd == CMD_SAVED_LD) begin
         for (int i = 0; i < NUM_PARAMS; i++)
            pend_q[i] <= cset_q[i] ? cdef_q[i] : factory_val(i);
      end else if (wd_go && 32'(pix_q) < NUM_PARAMS) begin
         // location bytes at index 15 of each string are kept as terminators
         if (32'(pix_q) == RATE_IX || (32'(pix_q) % LOC_LEN) != LOC_LEN - 1)
            pend_q[pix_q] <= wdata_q[7:0];
      end
   end

   // active layer, loaded from pending on any apply event
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < NUM_PARAMS; i++) act_q[i] <= factory_val(i);
      end else if (apply_ev) begin
         for (int i = 0; i < NUM_PARAMS; i++) act_q[i] <= pend_q[i];
      end
   end

   // non-volatile copy; the rate word follows the active layer without a write
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < NUM_PARAMS; i++) nv_q[i] <= factory_val(i);
      end else begin
         if (cmd_go && cmd == CMD_WRITE) begin
            for (int i = 0; i < NUM_PARAMS; i++) nv_q[i] <= act_q[i];
         end
         nv_q[RATE_IX] <= act_q[RATE_IX];
      end
   end

   // custom defaults: capture arms, next parameter write lands here too
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         capture_q <= 1'b0;
         reject_q  <= 1'b0;
         for (int i = 0; i < NUM_PARAMS; i++) begin
            cdef_q[i] <= 8'h00;
            cset_q[i] <= 1'b0;
         end
      end else if (cmd_go && def_cmd && remote) begin
         reject_q <= 1'b1;
      end else if (cmd_go && cmd == CMD_CLR_DEF) begin
         reject_q  <= 1'b0;
         capture_q <= 1'b0;
         for (int i = 0; i < NUM_PARAMS; i++) cset_q[i] <= 1'b0;
      end else if (cmd_go && cmd == CMD_CAPTURE) begin
         reject_q  <= 1'b0;
         capture_q <= 1'b1;
      end else if (wd_go && capture_q && 32'(pix_q) < NUM_PARAMS) begin
         capture_q      <= 1'b0;
         cdef_q[pix_q]  <= wdata_q[7:0];
         cset_q[pix_q]  <= 1'b1;
      end else if (cmd_go) begin
         capture_q <= 1'b0;                     // any other accepted command consumes the capture
         reject_q  <= 1'b0;
      end
   end

   // command mode, delayed reset and bootloader entry
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cmd_mode_q  <= 1'b0;
         rst_pend_q  <= 1'b0;
         rst_cnt_q   <= 32'h0000_0000;
         SOFT_RESET  <= 1'b0;
         BOOT_ENTER  <= 1'b0;
      end else begin
         SOFT_RESET <= 1'b0;
         BOOT_ENTER <= 1'b0;
         if (cmd_go && cmd == CMD_ENTER) cmd_mode_q <= 1'b1;
         if (cmd_go && (cmd == CMD_LEAVE || cmd == CMD_TIMEOUT)) cmd_mode_q <= 1'b0;
         if (cmd_go && cmd == CMD_BOOTLDR && !remote && !boot_bad_q)
            BOOT_ENTER <= 1'b1;
         if (cmd_go && cmd == CMD_SOFT_RST && !rst_pend_q) begin
            rst_pend_q <= 1'b1;
            rst_cnt_q  <= 32'h0000_0000;
         end else if (rst_pend_q) begin
            if (rst_cnt_q == RST_CYCLES - 1) begin
               rst_pend_q <= 1'b0;
               SOFT_RESET <= 1'b1;
               cmd_mode_q <= 1'b0;
            end else begin
               rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
            end
         end
      end
   end

   // index and image compatibility; a low image blocks boot until a good one arrives
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         pix_q       <= '0;
         fw_compat_q <= 16'h0000;
         boot_bad_q  <= 1'b0;
      end else if (wr_fire && awaddr_q == OFS_PARAM_IX) begin
         pix_q <= wdata_q[PARAM_IX_W-1:0];
      end else if (wr_fire && awaddr_q == OFS_FW_COMPAT) begin
         fw_compat_q <= wdata_q[15:0];
         boot_bad_q  <= wdata_q[15:0] < HW_COMPAT;
      end
   end

   // measurements cross from outside: two flops each
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         sup_s1_q <= 16'h0000;
         sup_q    <= 16'h0000;
         tmp_s1_q <= 16'h0000;
         tmp_q    <= 16'h0000;
      end else begin
         sup_s1_q <= SUPPLY_MV;
         sup_q    <= sup_s1_q;
         tmp_s1_q <= TEMP_C;
         tmp_q    <= tmp_s1_q;
      end
   end

   // crc over the active set; recomputed every cycle, costs a wide xor tree
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         crc_q <= 16'hffff;
      end else begin
         logic [15:0] c;
         c = 16'hffff;
         for (int i = 0; i < NUM_PARAMS; i++) c = crc_byte(c, act_q[i]);
         crc_q <= c;
      end
   end

   // rate output follows the active layer, so it switches only on apply
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) SERIAL_RATE <= RATE_DEFAULT;
      else       SERIAL_RATE <= act_q[RATE_IX];
   end

   // read channel
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         S_ARREADY <= 1'b0;
         S_RVALID  <= 1'b0;
         S_RDATA   <= 32'h0000_0000;
         S_RRESP   <= 2'b00;
      end else begin
         S_ARREADY <= !S_ARREADY && !S_RVALID;
         if (S_ARVALID && S_ARREADY) begin
            S_RVALID <= 1'b1;
            S_RRESP  <= 2'b00;
            S_RDATA  <= 32'h0000_0000;
            unique case (S_ARADDR)
               OFS_STATUS: S_RDATA[5:0] <= {reject_q, boot_bad_q, capture_q, 1'b0,
                                            rst_pend_q, cmd_mode_q};
               OFS_PARAM_IX: S_RDATA[PARAM_IX_W-1:0] <= pix_q;
               OFS_PEND_RD:  S_RDATA[7:0] <= pend_q[pix_q];
               OFS_ACT_RD:   S_RDATA[7:0] <= act_q[pix_q];
               OFS_FW_VER:   S_RDATA[15:0] <= FW_VERSION;
               OFS_HW_VAR:   S_RDATA[15:0] <= HW_VARIANT;
               OFS_POWER:    S_RDATA[0] <= POWER_STD;
               OFS_SUPPLY:   S_RDATA[15:0] <= sup_q;
               OFS_TEMP:     S_RDATA[15:0] <= tmp_q;
               OFS_CRC:      S_RDATA[15:0] <= crc_q;
               OFS_FW_COMPAT: S_RDATA[15:0] <= fw_compat_q;
               OFS_RATE:     S_RDATA[7:0] <= SERIAL_RATE;
               OFS_CMD, OFS_PARAM_WD: S_RDATA <= 32'h0000_0000;
               default:      S_RRESP <= 2'b10;
            endcase
         end else if (S_RVALID && S_RREADY) begin
            S_RVALID <= 1'b0;
         end
      end
   end

   // checks
   fw_range_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      FW_VERSION[15:12] == 4'h2)
      else $error("firmware version out of range");
   apply_copy_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      apply_ev |=> act_q[RATE_IX] == $past(pend_q[RATE_IX]))
      else $error("active rate not loaded on apply");
   rate_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      !apply_ev ##1 !apply_ev |=> $stable(SERIAL_RATE))
      else $error("serial rate changed without apply");
   boot_local_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      BOOT_ENTER |-> $past(cmd_go && !remote && cmd == CMD_BOOTLDR))
      else $error("bootloader entered without local command");
   reset_delay_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      SOFT_RESET |-> !cmd_mode_q && $past(rst_pend_q))
      else $error("soft reset without pending delay");
   remote_def_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      cmd_go && def_cmd && remote |=> reject_q && $stable(capture_q))
      else $error("remote default command not rejected");
   write_nv_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      cmd_go && cmd == CMD_WRITE |=> nv_q[0] == $past(act_q[0]))
      else $error("write did not reach non-volatile copy");
   fact_load_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      cmd_go && cmd == CMD_FACT_LD |=> pend_q[0] == LOC_DEFAULT)
      else $error("factory load did not restore default");
   compat_a: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      boot_bad_q |-> fw_compat_q < HW_COMPAT)
      else $error("boot blocked with valid image");
endmodule

// *** sim/csc_meas_model.sv ***
/*
 Measurement side of the config store unit: supply and temperature sources,
 and counters of the reset and loader pulses. Assumes the unit's own clock.
*/
`timescale 1ns/10ps
module csc_meas_model #(
   parameter logic [15:0] MV  = 16'h0ce4,
   parameter logic [15:0] DEG = 16'hffff
)(
   input  wire logic   clk,        // system clock
   input  wire logic   rst_n,      // reset, active low
   input  wire logic   soft_reset, // reset request from unit
   input  wire logic   boot_enter, // loader request from unit
   output logic [15:0] supply_mv,  // supply reading
   output logic [15:0] temp_c,     // temperature reading
   output int          n_rst,      // reset pulses seen
   output int          n_boot      // loader pulses seen
);
   // quasi-static readings; minus one degree exercises the sign
   assign supply_mv = MV;
   assign temp_c    = DEG;
   // count pulses: a level stuck high counts every cycle and is caught
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         n_rst  <= 0;
         n_boot <= 0;
      end else begin
         n_rst  <= n_rst + int'(soft_reset);
         n_boot <= n_boot + int'(boot_enter);
      end
   end
endmodule

// *** sim/tb.sv ***
/*
 Testbench of the config store unit: AXI4-Lite read and write tasks and a
 sequence of command tests. Assumes the unit's register map and codes.
*/
`timescale 1ns/10ps
module tb;
   import csc_pkg::*;
   logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, soft_rst, boot_en;
   logic [7:0]  awaddr, araddr, rate;
   logic [31:0] wdata, rdata, rd_v, crc0;
   logic [1:0]  bresp, rresp, b_v, r_v;
   logic [15:0] mv, degc;
   int          n_rst, n_boot, mismatches, checks;
   logic [31:0] ev [5] = '{32'h2, 32'h3, 32'h4, 32'h305, 32'h105};

   csc_top #(.HW_VARIANT(16'h0077), .POWER_STD(1'b0), .RST_CYCLES(10)) dut (
      .SYS_CLK(clk), .RSTN(rstn), .S_AWADDR(awaddr), .S_AWVALID(awvalid),
      .S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(4'hf), .S_WVALID(wvalid),
      .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid), .S_BREADY(bready),
      .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready), .S_RDATA(rdata),
      .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready), .SUPPLY_MV(mv),
      .TEMP_C(degc), .SERIAL_RATE(rate), .SOFT_RESET(soft_rst), .BOOT_ENTER(boot_en));
   csc_meas_model meas (.clk(clk), .rst_n(rstn), .soft_reset(soft_rst),
      .boot_enter(boot_en), .supply_mv(mv), .temp_c(degc), .n_rst(n_rst),
      .n_boot(n_boot));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // both write channels offered together; nothing else until the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      b_v = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      rd_v = rdata;
      r_v = rresp;
      rready <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rd_v, e);
   endtask
   task automatic stchk(input int b, input logic e);
      rd(OFS_STATUS);
      chk({31'h0, rd_v[b]}, {31'h0, e});
   endtask
   task automatic setp(input logic [7:0] ix, input logic [7:0] v);
      wr(OFS_PARAM_IX, {24'h0, ix});
      wr(OFS_PARAM_WD, {24'h0, v});
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // the whole sequence needs well under a hundred microseconds
   initial begin
      #100us;
      mismatches++;
      give_verdict();
   end
   initial begin
      {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata} = 48'h0;
      repeat (5) @(posedge clk);
      chk({24'h0, rate}, 32'h03);
      rstn <= 1'b1;
      rd(OFS_FW_VER);
      chk({31'h0, rd_v >= 32'h2000 && rd_v <= 32'h2fff}, 32'h1);
      rdchk(OFS_HW_VAR, 32'h77);
      rdchk(OFS_POWER, 32'h0);
      rdchk(OFS_SUPPLY, 32'hce4);
      rd(OFS_TEMP);
      chk({16'h0, rd_v[15:0]}, 32'hffff);
      rd(8'h3c);
      chk({30'h0, r_v}, 32'h2);
      // each string starts as one space followed by nothing
      for (int i = 0; i < 48; i += 16) begin
         wr(OFS_PARAM_IX, i);
         rdchk(OFS_ACT_RD, 32'h20);
      end
      wr(OFS_PARAM_IX, 32'h1);
      rdchk(OFS_ACT_RD, 32'h0);
      cmd_seq();
   end
   // command layer tests
   task automatic cmd_seq;
      wr(OFS_CMD, 32'(CMD_ENTER));
      setp(8'd15, 8'h41);
      rdchk(OFS_PEND_RD, 32'h0);
      rd(OFS_CRC);
      crc0 = rd_v;
      setp(8'(RATE_IX), 8'h07);
      rdchk(OFS_PEND_RD, 32'h07);
      rdchk(OFS_ACT_RD, 32'h03);
      chk({24'h0, rate}, 32'h03);
      wr(OFS_CMD, 32'(CMD_APPLY));
      rdchk(OFS_ACT_RD, 32'h07);
      chk({24'h0, rate}, 32'h07);
      rd(OFS_CRC);
      chk({31'h0, rd_v !== crc0}, 32'h1);
      // leave, timeout, frame 08, remote 17 with and without option bit 1;
      // the rate output lags the apply edge by a cycle, so look off the edge
      for (int k = 0; k < 5; k++) begin
         wr(OFS_CMD, 32'(CMD_ENTER));
         setp(8'(RATE_IX), 8'(8 + k));
         wr(OFS_CMD, ev[k]);
         @(negedge clk);
         chk({24'h0, rate}, 32'(k < 4 ? 8 + k : 11));
      end
      // the rate register at OFS_RATE is read-only: refused, value kept
      wr(OFS_RATE, 32'h05);
      chk({30'h0, b_v}, 32'h2);
      rdchk(OFS_RATE, 32'h0b);
      wr(OFS_CMD, 32'h100 | CMD_CAPTURE);
      stchk(ST_REJECT, 1'b1);
      wr(OFS_CMD, 32'(CMD_CAPTURE));
      wr(OFS_PARAM_WD, 32'h09);
      wr(OFS_CMD, 32'(CMD_FACT_LD));
      rdchk(OFS_PEND_RD, 32'h03);
      wr(OFS_CMD, 32'(CMD_SAVED_LD));
      rdchk(OFS_PEND_RD, 32'h09);
      stchk(ST_CMD_MODE, 1'b1);
      wr(OFS_CMD, 32'(CMD_CLR_DEF));
      rdchk(OFS_PEND_RD, 32'h09);
      wr(OFS_CMD, 32'(CMD_SAVED_LD));
      rdchk(OFS_PEND_RD, 32'h03);
      wr(OFS_CMD, 32'(CMD_WRITE));
      chk({30'h0, b_v}, 32'h0);
      // loader only from the local side, then blocked by a bad image
      wr(OFS_CMD, 32'(CMD_BOOTLDR));
      wr(OFS_CMD, 32'h100 | CMD_BOOTLDR);
      repeat (2) @(posedge clk);
      chk(n_boot, 32'h1);
      wr(OFS_FW_COMPAT, 32'h0);
      wr(OFS_CMD, 32'(CMD_BOOTLDR));
      stchk(ST_BOOT_BAD, 1'b1);
      chk(n_boot, 32'h1);
      wr(OFS_CMD, 32'(CMD_SOFT_RST));
      chk({30'h0, b_v}, 32'h0);
      chk(n_rst, 32'h0);
      repeat (12) @(posedge clk);
      chk(n_rst, 32'h1);
      stchk(ST_CMD_MODE, 1'b0);
      give_verdict();
   endtask
endmodule
